// [shared/sqc_pkg.sv]
package sqc_pkg;
    // ==========================================================
    // Flash command codes and unlock addresses.
    localparam logic [10:0] UNLOCK_ADDR_A = 11'h555;
    localparam logic [10:0] UNLOCK_ADDR_B = 11'h2aa;
    localparam logic [10:0] QUERY_ADDR = 11'h055;
    localparam logic [7:0] CMD_UNLOCK_A = 8'haa;
    localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
    localparam logic [7:0] CMD_SECURE_ENTER = 8'h88;
    localparam logic [7:0] CMD_SECURE_EXIT_A = 8'h90;
    localparam logic [7:0] CMD_SECURE_EXIT_B = 8'h00;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_PROTECT = 8'h60;
    // ==========================================================
    // Secured region layout and status flag bit positions.
    localparam logic [10:0] SECURE_CUST_BASE = 11'h040;
    localparam logic [10:0] SECURE_LAST = 11'h07f;
    localparam int FACTORY_LOCK_BIT = 7;
    localparam int CUSTOMER_LOCK_BIT = 6;
    // ==========================================================
    // Avalon register offsets (word index = byte address / 4).
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA = 4'h4;
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0;
    // ==========================================================
    // Bus phase timing: 60 ns per phase at 50 MHz rounds up to 3 cycles.
    localparam int CLK_NS = 20;
    localparam int PHASE_NS = 60;
    localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    // ==========================================================
    // Operations software may order.
    typedef enum logic [3:0] {
        SQC_OP_READ, SQC_OP_WRITE, SQC_OP_QUERY_ENTER, SQC_OP_RESET,
        SQC_OP_SECURE_ENTER, SQC_OP_SECURE_EXIT, SQC_OP_PROGRAM, SQC_OP_PROTECT
    } sqc_op_t;
    // Flash pin bundle driven by the controller.
    typedef struct packed {
        logic cs1_n;
        logic cs2_n;
        logic oe_n;
        logic we_n;
        logic [21:0] addr;
    } sqc_pins_t;
endpackage

// [hdl/sqc_host.sv]
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sqc_host (
    input wire logic mclk, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic [3:0] avs_address, // Word register index.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic [31:0] avs_writedata, // Write data.
    output logic [31:0] avs_readdata, // Read data.
    output logic avs_waitrequest, // Stall.
    output sqc_pkg::sqc_pins_t flash_pins, // Flash control and address pins.
    output logic [15:0] flash_dq_o, // Flash data out.
    output logic flash_dq_oe_n, // Low while the host drives the data bus.
    input wire logic [15:0] flash_dq_i, // Flash data in.
    output logic flash_reset_n, // Flash hardware reset, kept high.
    output logic flash_accelerated_program_n // Acceleration pin, kept high (no acceleration).
);
    // ==========================================================
    // Sequencer types.
    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_NEXT} sqc_state_t;
    localparam logic [7:0] PHASE_LAST = 8'(sqc_pkg::PHASE_CYC - 1);

    sqc_state_t state_q, state_d;
    logic [3:0] op_q;
    logic [21:0] addr_q;
    logic [15:0] wdata_q, rdata_q;
    logic [7:0] tick_q;
    logic [2:0] step_q;
    logic busy_q, secure_q, query_q, wait_q;
    logic reset_n_q, accel_n_q;
    logic [31:0] rd_q;
    sqc_pkg::sqc_pins_t pins_q;
    logic [15:0] dq_o_q;
    logic dq_oe_n_q;
    logic [15:0] sync1_q, sync2_q;

    // ==========================================================
    // Cycle list per operation: address, data, last step, read flag.
    logic [21:0] cyc_addr;
    logic [15:0] cyc_data;
    logic [2:0] last_step;
    logic cyc_is_read;
    always_comb begin
        cyc_addr = addr_q;
        cyc_data = wdata_q;
        cyc_is_read = 1'b0;
        last_step = 3'd0;
        unique case (sqc_pkg::sqc_op_t'(op_q))
            sqc_pkg::SQC_OP_READ: begin
                cyc_is_read = 1'b1;
            end
            sqc_pkg::SQC_OP_WRITE: begin
                last_step = 3'd0;
            end
            sqc_pkg::SQC_OP_QUERY_ENTER: begin
                cyc_addr = {11'h0, sqc_pkg::QUERY_ADDR};
                cyc_data = {8'h0, sqc_pkg::CMD_QUERY};
            end
            sqc_pkg::SQC_OP_RESET: begin
                cyc_data = {8'h0, sqc_pkg::CMD_RESET};
            end
            default: begin
                // Unlocked sequences: two unlock cycles then the command; program and secure exit add a fourth cycle.
                last_step = (op_q == 4'(sqc_pkg::SQC_OP_PROGRAM) || op_q == 4'(sqc_pkg::SQC_OP_SECURE_EXIT))
                            ? 3'd3 : 3'd2;
                unique case (step_q)
                    3'd0: begin
                        cyc_addr = {11'h0, sqc_pkg::UNLOCK_ADDR_A};
                        cyc_data = {8'h0, sqc_pkg::CMD_UNLOCK_A};
                    end
                    3'd1: begin
                        cyc_addr = {11'h0, sqc_pkg::UNLOCK_ADDR_B};
                        cyc_data = {8'h0, sqc_pkg::CMD_UNLOCK_B};
                    end
                    3'd2: begin
                        cyc_addr = {11'h0, sqc_pkg::UNLOCK_ADDR_A};
                        cyc_data = (op_q == 4'(sqc_pkg::SQC_OP_SECURE_ENTER)) ? {8'h0, sqc_pkg::CMD_SECURE_ENTER} :
                                   (op_q == 4'(sqc_pkg::SQC_OP_SECURE_EXIT)) ? {8'h0, sqc_pkg::CMD_SECURE_EXIT_A} :
                                   (op_q == 4'(sqc_pkg::SQC_OP_PROGRAM)) ? {8'h0, sqc_pkg::CMD_PROGRAM} :
                                   {8'h0, sqc_pkg::CMD_PROTECT};
                        if (op_q == 4'(sqc_pkg::SQC_OP_PROTECT)) begin
                            cyc_addr = addr_q;
                        end
                    end
                    default: begin
                        cyc_data = (op_q == 4'(sqc_pkg::SQC_OP_SECURE_EXIT)) ? {8'h0, sqc_pkg::CMD_SECURE_EXIT_B}
                                   : wdata_q;
                    end
                endcase
            end
        endcase
    end

    // ==========================================================
    // Bus decode; a new order is refused while busy (bit 0 of status).
    wire logic tick_done = (tick_q == PHASE_LAST);
    // A write takes effect only at the edge where waitrequest is low, so it lands exactly once.
    wire logic wr_take = avs_write && !wait_q;
    wire logic go = wr_take && avs_address == sqc_pkg::REG_CTRL && !busy_q;
    wire logic last = (step_q == last_step);
    wire logic [31:0] rd_mux =
        (avs_address == sqc_pkg::REG_CTRL) ? {28'h0, op_q} :
        (avs_address == sqc_pkg::REG_ADDR) ? {10'h0, addr_q} :
        (avs_address == sqc_pkg::REG_WDATA) ? {16'h0, wdata_q} :
        (avs_address == sqc_pkg::REG_STATUS) ? {29'h0, query_q, secure_q, busy_q} :
        (avs_address == sqc_pkg::REG_RDATA) ? {16'h0, rdata_q} : 32'h0;

    // Sequencer: setup with address, strobe, hold, then next cycle.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: state_d = go ? ST_SETUP : ST_IDLE;
            ST_SETUP: state_d = tick_done ? ST_STROBE : ST_SETUP;
            ST_STROBE: state_d = tick_done ? ST_HOLD : ST_STROBE;
            ST_HOLD: state_d = tick_done ? ST_NEXT : ST_HOLD;
            ST_NEXT: state_d = last ? ST_IDLE : ST_SETUP;
        endcase
    end

    // Phase timer and state register.
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            tick_q <= 8'h0;
        end else begin
            state_q <= state_d;
            tick_q <= (state_d != state_q || state_q == ST_IDLE) ? 8'h0 : tick_q + 8'h1;
        end
    end

    // Order registers and step counter.
    always_ff @(posedge mclk) begin
        if (srst) begin
            op_q <= sqc_pkg::CTRL_RESET_VAL[3:0];
            addr_q <= 22'h0;
            wdata_q <= 16'h0;
            step_q <= 3'd0;
            busy_q <= 1'b0;
        end else begin
            if (wr_take && avs_address == sqc_pkg::REG_ADDR && !busy_q) addr_q <= avs_writedata[21:0];
            if (wr_take && avs_address == sqc_pkg::REG_WDATA && !busy_q) wdata_q <= avs_writedata[15:0];
            if (go) op_q <= avs_writedata[3:0];
            if (go) busy_q <= 1'b1;
            else if (state_q == ST_NEXT && last) busy_q <= 1'b0;
            if (go) step_q <= 3'd0;
            else if (state_q == ST_NEXT && !last) step_q <= step_q + 3'd1;
        end
    end

    // Mode tracking: secured mapping and query mode.
    always_ff @(posedge mclk) begin
        if (srst) begin
            secure_q <= 1'b0;
            query_q <= 1'b0;
        end else if (state_q == ST_NEXT && last) begin
            if (op_q == 4'(sqc_pkg::SQC_OP_SECURE_ENTER)) secure_q <= 1'b1;
            if (op_q == 4'(sqc_pkg::SQC_OP_SECURE_EXIT)) secure_q <= 1'b0;
            if (op_q == 4'(sqc_pkg::SQC_OP_QUERY_ENTER)) query_q <= 1'b1;
            if (op_q == 4'(sqc_pkg::SQC_OP_RESET)) query_q <= 1'b0;
        end
    end

    // Pin drive: chip select and write enable low with output enable high for writes.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pins_q <= '{cs1_n: 1'b1, cs2_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 22'h0};
            dq_o_q <= 16'h0;
            dq_oe_n_q <= 1'b1;
            reset_n_q <= 1'b1;
            accel_n_q <= 1'b1;
        end else begin
            reset_n_q <= 1'b1;
            accel_n_q <= 1'b1;
            pins_q.addr <= cyc_addr;
            pins_q.cs1_n <= !(state_d inside {ST_SETUP, ST_STROBE, ST_HOLD});
            pins_q.cs2_n <= 1'b1;
            pins_q.we_n <= !(state_d == ST_STROBE && !cyc_is_read);
            pins_q.oe_n <= !(state_d inside {ST_STROBE, ST_HOLD} && cyc_is_read);
            dq_o_q <= cyc_data;
            dq_oe_n_q <= !(state_d inside {ST_SETUP, ST_STROBE, ST_HOLD} && !cyc_is_read);
        end
    end

    // Read data capture through two stages, sampled at end of hold.
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_q <= 16'h0;
            sync2_q <= 16'h0;
            rdata_q <= 16'h0;
        end else begin
            sync1_q <= flash_dq_i;
            sync2_q <= sync1_q;
            if (state_q == ST_HOLD && tick_done && cyc_is_read) rdata_q <= sync2_q;
        end
    end

    // Avalon answer: one wait cycle, then data.
    always_ff @(posedge mclk) begin
        if (srst) begin
            wait_q <= 1'b1;
            rd_q <= 32'h0;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
            rd_q <= rd_mux;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rd_q;
    assign flash_pins = pins_q;
    assign flash_dq_o = dq_o_q;
    assign flash_dq_oe_n = dq_oe_n_q;
    assign flash_reset_n = reset_n_q;
    assign flash_accelerated_program_n = accel_n_q;
endmodule // sqc_host
`default_nettype wire

// [sim/sqc_host_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// Timing relations between the register bus and the flash pins.
module sqc_host_properties (
    input wire logic mclk, // Clock.
    input wire logic srst, // Reset.
    input wire logic [3:0] avs_address, // Index.
    input wire logic avs_read, // Read.
    input wire logic avs_write, // Write.
    input wire logic [31:0] avs_readdata, // Data.
    input wire logic avs_waitrequest, // Stall.
    input wire sqc_pkg::sqc_pins_t flash_pins, // Pins.
    input wire logic flash_dq_oe_n, // Drive enable.
    input wire logic flash_reset_n, // Reset pin.
    input wire logic flash_accelerated_program_n // Acceleration pin.
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Wait low twice.");
    a_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("Late answer.");
    a_write_gated: assert property (!flash_pins.we_n |-> flash_pins.oe_n && !flash_pins.cs1_n)
        else $error("Bad write strobes.");
    a_data_driven: assert property (!flash_pins.we_n |-> !flash_dq_oe_n)
        else $error("Write without data.");
    a_no_clash: assert property (!flash_pins.oe_n |-> flash_dq_oe_n && flash_pins.we_n)
        else $error("Read while driving.");
    a_pins_high: assert property (flash_reset_n && flash_accelerated_program_n)
        else $error("Reset or accel low.");
    a_we_width: assert property ($fell(flash_pins.we_n) |=> !flash_pins.we_n[*2] ##1 flash_pins.we_n)
        else $error("Write pulse width.");
    a_cs_setup: assert property ($fell(flash_pins.we_n) |-> $past(flash_pins.cs1_n, 3) == 1'b0)
        else $error("Select setup short.");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h4 |-> avs_readdata == 32'h0)
        else $error("Unmapped read not zero.");
endmodule // sqc_host_properties
bind sqc_host sqc_host_properties u_props (.mclk, .srst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .flash_pins, .flash_dq_oe_n, .flash_reset_n, .flash_accelerated_program_n);
`default_nettype wire

// [sim/sqc_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Behavioural flash: commands, secured region and query table.
module sqc_flash_model (
    input wire sqc_pkg::sqc_pins_t pins, // Pins.
    input wire logic [15:0] dq_o, // Host data.
    input wire logic dq_oe_n, // Host drives.
    input wire logic lockout_voltage_detect, // Low supply indication.
    output logic [15:0] dq_i // Read data.
);
    localparam logic [359:0] QT = {256'h5152590200400000000000273600000300090004000400180100000003070020,
        104'h00fd0000010700200000000000};
    logic [15:0] sec_mem [128];
    logic [15:0] arr_mem [256];
    logic [1:0] unl_q;
    logic prog_q, exit_q, qry_q, sec_q, cust_q, stat_q;
    wire [21:0] a = pins.addr;
    wire [7:0] c = dq_o[7:0];
    wire [15:0] arr_w = (sec_q && a < 22'h80) ? sec_mem[a[6:0]] : arr_mem[a[7:0]];
    wire [15:0] qry_w = (a >= 22'h10 && a <= 22'h3c)
        ? {8'h00, QT[359 - 8 * (a - 22'h10) -: 8]} : 16'h0;
    wire [15:0] rd_w = stat_q ? {8'h00, 1'b1, cust_q, 6'h00} : (qry_q ? qry_w : arr_w);
    // A released bus shows the inverse of the word.
    assign dq_i = (!pins.cs1_n && !pins.oe_n && pins.we_n) ? rd_w : ~rd_w;
    // Shipped state: read mode, customer half open, all erased.
    initial begin
        {unl_q, prog_q, exit_q, qry_q, sec_q, cust_q, stat_q} = '0;
        foreach (sec_mem[i]) sec_mem[i] = 16'hffff;
        foreach (arr_mem[i]) arr_mem[i] = 16'hffff;
    end
    // Commands are taken as write enable rises; low supply drops back to read mode.
    always @(posedge pins.we_n or posedge lockout_voltage_detect) begin
        if (lockout_voltage_detect) begin
            {unl_q, prog_q, exit_q, qry_q, sec_q, stat_q} <= '0;
        end else if ((!pins.cs1_n || !pins.cs2_n) && pins.oe_n && !dq_oe_n) begin
            stat_q <= 1'b0;
            unl_q <= 2'd0;
            if (prog_q) begin
                prog_q <= 1'b0;
                if (!sec_q) arr_mem[a[7:0]] <= arr_mem[a[7:0]] & dq_o;
                else if (a[6] && !cust_q) sec_mem[a[6:0]] <= sec_mem[a[6:0]] & dq_o;
            end else if (c == 8'hf0) qry_q <= 1'b0;
            // A pending program takes this write as its data, so no query starts during one.
            else if (c == 8'h98 && a[10:0] == 11'h055) qry_q <= 1'b1;
            else if (sec_q && c == 8'h60) {cust_q, stat_q} <= 2'b11;
            else if (exit_q && c == 8'h00) {sec_q, exit_q} <= 2'b00;
            else if (unl_q == 2'd2) begin
                prog_q <= (c == 8'ha0);
                exit_q <= (c == 8'h90);
                if (c == 8'h88) sec_q <= 1'b1;
            end else if (c == 8'haa && a[10:0] == 11'h555) unl_q <= 2'd1;
            else if (unl_q == 2'd1 && c == 8'h55 && a[10:0] == 11'h2aa) unl_q <= 2'd2;
        end
    end
endmodule // sqc_flash_model
`default_nettype wire

// [sim/tb_sqc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sqc_host;
    localparam logic [359:0] QT = {256'h5152590200400000000000273600000300090004000400180100000003070020,
        104'h00fd0000010700200000000000};
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic lockout_voltage_detect = 1'b0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, flash_dq_oe_n;
    sqc_pkg::sqc_pins_t flash_pins;
    logic [15:0] flash_dq_o, flash_dq_i;
    int n_fail = 0;
    int checks = 0;
    // Clock at 50 MHz.
    always #10 mclk = ~mclk;
    sqc_host dut_u (.mclk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .flash_pins, .flash_dq_o, .flash_dq_oe_n, .flash_dq_i, .flash_reset_n(),
        .flash_accelerated_program_n());
    sqc_flash_model flash_u (.pins(flash_pins), .dq_o(flash_dq_o), .dq_oe_n(flash_dq_oe_n), .dq_i(flash_dq_i),
        .lockout_voltage_detect(lockout_voltage_detect));
    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One bus transfer, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            $display("BAD %0t bus answer timeout", $time);
            n_fail++;
            give_verdict();
        end
    endtask
    // Order one flash operation and poll until idle.
    task automatic op(input sqc_pkg::sqc_op_t o, input logic [21:0] a, input logic [15:0] d);
        int i;
        bus(1'b1, sqc_pkg::REG_ADDR, {10'h000, a});
        bus(1'b1, sqc_pkg::REG_WDATA, {16'h0000, d});
        bus(1'b1, sqc_pkg::REG_CTRL, {28'h0000000, o});
        for (i = 0; i < 200; i++) begin
            bus(1'b0, sqc_pkg::REG_STATUS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        if (i == 200) begin
            $display("BAD %0t busy timeout", $time);
            n_fail++;
            give_verdict();
        end
    endtask
    task automatic rdchk(input logic [21:0] a, input logic [15:0] exp);
        op(sqc_pkg::SQC_OP_READ, a, 16'h0);
        bus(1'b0, sqc_pkg::REG_RDATA, 32'h0);
        chk(rd[15:0], exp);
    endtask
    task automatic t_program();
        op(sqc_pkg::SQC_OP_PROGRAM, 22'h21, 16'h1234);
        rdchk(22'h21, 16'h1234);
        op(sqc_pkg::SQC_OP_PROGRAM, 22'h55, 16'h0098);
        rdchk(22'h55, 16'h0098);
        bus(1'b0, 4'h9, 32'h0);
        chk(rd[15:0], 16'h0);
        $display("program test done");
    endtask
    task automatic t_query();
        int k;
        logic [15:0] exp_w;
        op(sqc_pkg::SQC_OP_QUERY_ENTER, 22'h0, 16'h0);
        bus(1'b0, sqc_pkg::REG_STATUS, 32'h0);
        chk({15'h0, rd[2]}, 16'h1);
        for (k = 15; k <= 61; k++) begin
            exp_w = (k < 16 || k > 60) ? 16'h0 : {8'h00, QT[359 - 8 * (k - 16) -: 8]};
            rdchk(k[21:0], exp_w);
        end
        op(sqc_pkg::SQC_OP_RESET, 22'h3ff, 16'h0);
        rdchk(22'h10, 16'hffff);
        op(sqc_pkg::SQC_OP_WRITE, 22'h055, 16'h0098);
        rdchk(22'h11, 16'h0052);
        op(sqc_pkg::SQC_OP_WRITE, 22'h000, 16'h00f0);
        rdchk(22'h11, 16'hffff);
        $display("query test done");
    endtask
    task automatic t_secure();
        op(sqc_pkg::SQC_OP_SECURE_ENTER, 22'h0, 16'h0);
        rdchk(22'h21, 16'hffff);
        op(sqc_pkg::SQC_OP_PROGRAM, 22'h05, 16'h1234);
        rdchk(22'h05, 16'hffff);
        op(sqc_pkg::SQC_OP_PROGRAM, 22'h45, 16'h00a5);
        rdchk(22'h45, 16'h00a5);
        op(sqc_pkg::SQC_OP_PROTECT, 22'h0, 16'h0);
        rdchk(22'h0, 16'h00c0);
        op(sqc_pkg::SQC_OP_PROGRAM, 22'h46, 16'h0);
        rdchk(22'h46, 16'hffff);
        op(sqc_pkg::SQC_OP_SECURE_EXIT, 22'h0, 16'h0);
        rdchk(22'h21, 16'h1234);
        $display("secured test done");
    endtask
    task automatic t_lockout();
        @(posedge mclk);
        lockout_voltage_detect <= 1'b1;
        op(sqc_pkg::SQC_OP_PROGRAM, 22'h22, 16'h0000);
        rdchk(22'h22, 16'hffff);
        @(posedge mclk);
        lockout_voltage_detect <= 1'b0;
        op(sqc_pkg::SQC_OP_PROGRAM, 22'h22, 16'h0f0f);
        rdchk(22'h22, 16'h0f0f);
        $display("lockout test done");
    endtask
    // Reset for two cycles, then run the scenarios.
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_program();
        t_query();
        t_secure();
        t_lockout();
        give_verdict();
    end
endmodule // tb_sqc_host
`default_nettype wire
